// >>> hw/jbsp_pkg.sv
// Types shared by the test access port controller and the port logic.
package jbsp_pkg;
  // Sixteen controller states, one-hot.
  typedef enum logic [15:0] {
    JBSP_RESET = 16'h0001,
    JBSP_IDLE = 16'h0002,
    JBSP_SEL_DR = 16'h0004,
    JBSP_CAP_DR = 16'h0008,
    JBSP_SH_DR = 16'h0010,
    JBSP_EX1_DR = 16'h0020,
    JBSP_PAU_DR = 16'h0040,
    JBSP_EX2_DR = 16'h0080,
    JBSP_UPD_DR = 16'h0100,
    JBSP_SEL_IR = 16'h0200,
    JBSP_CAP_IR = 16'h0400,
    JBSP_SH_IR = 16'h0800,
    JBSP_EX1_IR = 16'h1000,
    JBSP_PAU_IR = 16'h2000,
    JBSP_EX2_IR = 16'h4000,
    JBSP_UPD_IR = 16'h8000
  } jbsp_state_t;
  // Data register placed between the serial input and output.
  typedef enum logic [2:0] {
    JBSP_DR_BYPASS = 3'h0,
    JBSP_DR_ID = 3'h1,
    JBSP_DR_BSR = 3'h2,
    JBSP_DR_ADDR = 3'h3,
    JBSP_DR_DATA = 3'h4
  } jbsp_sel_t;
endpackage : jbsp_pkg

// >>> hw/jbsp_regs.svh
// Constants of the boundary-scan test port: opcodes, widths and capture values.
`ifndef JBSP_REGS_SVH
`define JBSP_REGS_SVH
`define JBSP_IR_W 10
`define JBSP_IR_CAPTURE 10'h001
`define JBSP_OP_EXTEST 10'h000
`define JBSP_OP_SAMPLE 10'h055
`define JBSP_OP_IDCODE 10'h059
`define JBSP_OP_BYPASS 10'h3FF
`define JBSP_OP_PROG_ENTER 10'h2CC
`define JBSP_OP_PROG_EXIT 10'h201
`define JBSP_OP_PROG_ADDR 10'h203
`define JBSP_OP_PROG_DATA 10'h205
`define JBSP_ID_W 32
`define JBSP_BSR_W 8
`define JBSP_PROG_W 16
`define JBSP_STRAP_DLY 2'h2
`endif

// >>> hw/jbsp_tap.sv
// Sixteen-state test access port controller stepped by the mode-select input.
`timescale 1ns/1ps
module jbsp_tap (
  // Link clock and test reset.
  input wire logic i_tck,
  input wire logic i_rst_n,
  // Mode select.
  input wire logic i_tms,
  // Controller state.
  output jbsp_pkg::jbsp_state_t o_state
);
  jbsp_pkg::jbsp_state_t next_state;

  // Next state from mode select; every state has exactly two successors.
  always_comb begin
    case (o_state)
      jbsp_pkg::JBSP_RESET: next_state = i_tms ? jbsp_pkg::JBSP_RESET : jbsp_pkg::JBSP_IDLE;
      jbsp_pkg::JBSP_IDLE: next_state = i_tms ? jbsp_pkg::JBSP_SEL_DR : jbsp_pkg::JBSP_IDLE;
      jbsp_pkg::JBSP_SEL_DR: next_state = i_tms ? jbsp_pkg::JBSP_SEL_IR : jbsp_pkg::JBSP_CAP_DR;
      jbsp_pkg::JBSP_CAP_DR: next_state = i_tms ? jbsp_pkg::JBSP_EX1_DR : jbsp_pkg::JBSP_SH_DR;
      jbsp_pkg::JBSP_SH_DR: next_state = i_tms ? jbsp_pkg::JBSP_EX1_DR : jbsp_pkg::JBSP_SH_DR;
      jbsp_pkg::JBSP_EX1_DR: next_state = i_tms ? jbsp_pkg::JBSP_UPD_DR : jbsp_pkg::JBSP_PAU_DR;
      jbsp_pkg::JBSP_PAU_DR: next_state = i_tms ? jbsp_pkg::JBSP_EX2_DR : jbsp_pkg::JBSP_PAU_DR;
      jbsp_pkg::JBSP_EX2_DR: next_state = i_tms ? jbsp_pkg::JBSP_UPD_DR : jbsp_pkg::JBSP_SH_DR;
      jbsp_pkg::JBSP_UPD_DR: next_state = i_tms ? jbsp_pkg::JBSP_SEL_DR : jbsp_pkg::JBSP_IDLE;
      jbsp_pkg::JBSP_SEL_IR: next_state = i_tms ? jbsp_pkg::JBSP_RESET : jbsp_pkg::JBSP_CAP_IR;
      jbsp_pkg::JBSP_CAP_IR: next_state = i_tms ? jbsp_pkg::JBSP_EX1_IR : jbsp_pkg::JBSP_SH_IR;
      jbsp_pkg::JBSP_SH_IR: next_state = i_tms ? jbsp_pkg::JBSP_EX1_IR : jbsp_pkg::JBSP_SH_IR;
      jbsp_pkg::JBSP_EX1_IR: next_state = i_tms ? jbsp_pkg::JBSP_UPD_IR : jbsp_pkg::JBSP_PAU_IR;
      jbsp_pkg::JBSP_PAU_IR: next_state = i_tms ? jbsp_pkg::JBSP_EX2_IR : jbsp_pkg::JBSP_PAU_IR;
      jbsp_pkg::JBSP_EX2_IR: next_state = i_tms ? jbsp_pkg::JBSP_UPD_IR : jbsp_pkg::JBSP_SH_IR;
      jbsp_pkg::JBSP_UPD_IR: next_state = i_tms ? jbsp_pkg::JBSP_SEL_DR : jbsp_pkg::JBSP_IDLE;
      default: next_state = jbsp_pkg::JBSP_RESET;
    endcase
  end

  // State register; an illegal code falls back to reset through the default branch.
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state <= jbsp_pkg::JBSP_RESET;
    end else begin
      o_state <= next_state;
    end
  end

  // Five high mode-select samples reach reset from any state.
  tms_reset_a: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    (i_tms [*5]) |=> (o_state == jbsp_pkg::JBSP_RESET))
    else $error("five high mode samples did not reach reset");
endmodule : jbsp_tap

// >>> hw/jbsp_top.sv
// Boundary-scan test port with identification, bypass and programming access.
`timescale 1ns/1ps
`include "jbsp_regs.svh"
module jbsp_top #(
  parameter bit P_HAS_BSR = 1'b1,
  parameter logic [31:0] P_IDCODE = 32'h1234_5679 // Arbitrary identification value.
) (
  // System clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Test port pins.
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // Test port enable strap and user use of the port pins.
  input wire logic i_port_en,
  input wire logic i_user_tdo,
  input wire logic i_user_tdo_oe,
  output logic [2:0] o_user_in,
  output logic o_user_out,
  output logic o_user_oe,
  // Device pins and core side.
  input wire logic [`JBSP_BSR_W-1:0] i_pin_in,
  input wire logic [`JBSP_BSR_W-1:0] i_core_out,
  input wire logic [`JBSP_BSR_W-1:0] i_core_oe,
  output logic [`JBSP_BSR_W-1:0] o_pin_out,
  output logic [`JBSP_BSR_W-1:0] o_pin_oe,
  // Programming access to the nonvolatile store.
  output logic o_prog_mode,
  output logic o_prog_wr,
  output logic [`JBSP_PROG_W-1:0] o_prog_addr,
  output logic [`JBSP_PROG_W-1:0] o_prog_data
);
  jbsp_pkg::jbsp_state_t state;
  jbsp_pkg::jbsp_sel_t sel;
  logic [1:0] trst_q;
  logic trst_n;
  logic en_s1, en_s2, en_done, en_clk, en_t1, en_t2;
  logic [1:0] en_cnt;
  logic [`JBSP_IR_W-1:0] ir_sh, ir;
  logic bypass;
  logic [`JBSP_ID_W-1:0] id_sh;
  logic [`JBSP_BSR_W-1:0] pin_t1, pin_t2, bsr, upd, upd_c;
  logic [`JBSP_PROG_W-1:0] addr_sh, data_sh, addr_hold, data_hold;
  logic drive, upd_tog, wr_tog, prog_t;
  logic [2:0] upd_s, wr_s;
  logic drv_s1, drv_s2, prog_s1, prog_s2;
  logic [2:0] uin_s1, uin_s2;
  logic dr_out;

  // Picks the data register for an instruction; unknown codes fall to bypass.
  function automatic jbsp_pkg::jbsp_sel_t jbsp_decode(input logic [`JBSP_IR_W-1:0] op, input bit has_bsr);
    case (op)
      `JBSP_OP_IDCODE: jbsp_decode = jbsp_pkg::JBSP_DR_ID;
      `JBSP_OP_EXTEST, `JBSP_OP_SAMPLE: jbsp_decode = has_bsr ? jbsp_pkg::JBSP_DR_BSR : jbsp_pkg::JBSP_DR_BYPASS;
      `JBSP_OP_PROG_ADDR: jbsp_decode = jbsp_pkg::JBSP_DR_ADDR;
      `JBSP_OP_PROG_DATA: jbsp_decode = jbsp_pkg::JBSP_DR_DATA;
      default: jbsp_decode = jbsp_pkg::JBSP_DR_BYPASS;
    endcase
  endfunction : jbsp_decode

  // Test reset for the link domain: asserts at once, releases after two link edges.
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trst_q <= 2'h0;
    end else begin
      trst_q <= {trst_q[0], 1'b1};
    end
  end
  assign trst_n = trst_q[1];

  jbsp_tap u_tap (
    .i_tck(i_tck),
    .i_rst_n(trst_n),
    .i_tms(i_tms),
    .o_state(state)
  );

  assign sel = jbsp_decode(ir, P_HAS_BSR);

  // Enable strap: synchronised, then caught once after reset so the port role stays fixed.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_done <= 1'b0;
      en_clk <= 1'b0;
      en_cnt <= 2'h0;
    end else begin
      en_s1 <= i_port_en;
      en_s2 <= en_s1;
      // The count waits until the strap has passed both synchroniser stages.
      if (en_cnt != `JBSP_STRAP_DLY) begin
        en_cnt <= en_cnt + 2'h1;
      end
      if (en_cnt == `JBSP_STRAP_DLY && !en_done) begin
        en_clk <= en_s2;
        en_done <= 1'b1;
      end
    end
  end

  // Enable level carried into the link domain.
  always_ff @(posedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      en_t1 <= 1'b0;
      en_t2 <= 1'b0;
    end else begin
      en_t1 <= en_clk;
      en_t2 <= en_t1;
    end
  end

  // Instruction shift and update; reset selects identification.
  always_ff @(posedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh <= `JBSP_IR_CAPTURE;
      ir <= `JBSP_OP_IDCODE;
    end else begin
      if (state == jbsp_pkg::JBSP_RESET) begin
        ir <= `JBSP_OP_IDCODE;
      end
      if (state == jbsp_pkg::JBSP_CAP_IR) begin
        ir_sh <= `JBSP_IR_CAPTURE;
      end else if (state == jbsp_pkg::JBSP_SH_IR) begin
        ir_sh <= {i_tdi, ir_sh[`JBSP_IR_W-1:1]};
      end
      if (state == jbsp_pkg::JBSP_UPD_IR) begin
        ir <= ir_sh;
      end
    end
  end

  // Pins sampled into the link domain before capture.
  always_ff @(posedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      pin_t1 <= '0;
      pin_t2 <= '0;
    end else begin
      pin_t1 <= i_pin_in;
      pin_t2 <= pin_t1;
    end
  end

  // Data registers: capture, shift toward the output end, and update.
  always_ff @(posedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      bypass <= 1'b0;
      id_sh <= '0;
      bsr <= '0;
      upd <= '0;
      addr_sh <= '0;
      data_sh <= '0;
      addr_hold <= '0;
      data_hold <= '0;
      upd_tog <= 1'b0;
      wr_tog <= 1'b0;
    end else begin
      if (state == jbsp_pkg::JBSP_CAP_DR) begin
        bypass <= 1'b0;
        id_sh <= P_IDCODE | 32'h0000_0001;
        bsr <= pin_t2;
        data_sh <= data_hold;
      end else if (state == jbsp_pkg::JBSP_SH_DR) begin
        case (sel)
          jbsp_pkg::JBSP_DR_ID: id_sh <= {i_tdi, id_sh[`JBSP_ID_W-1:1]};
          jbsp_pkg::JBSP_DR_BSR: bsr <= {i_tdi, bsr[`JBSP_BSR_W-1:1]};
          jbsp_pkg::JBSP_DR_ADDR: addr_sh <= {i_tdi, addr_sh[`JBSP_PROG_W-1:1]};
          jbsp_pkg::JBSP_DR_DATA: data_sh <= {i_tdi, data_sh[`JBSP_PROG_W-1:1]};
          default: bypass <= i_tdi;
        endcase
      end else if (state == jbsp_pkg::JBSP_UPD_DR) begin
        // Preload and extest both load the output latch; only extest lets it reach the pins.
        if (sel == jbsp_pkg::JBSP_DR_BSR) begin
          upd <= bsr;
          upd_tog <= ~upd_tog;
        end
        if (sel == jbsp_pkg::JBSP_DR_ADDR) begin
          addr_hold <= addr_sh;
        end
        if (sel == jbsp_pkg::JBSP_DR_DATA && prog_t) begin
          data_hold <= data_sh;
          wr_tog <= ~wr_tog;
        end
      end
    end
  end

  // Mode levels are set as the instruction updates, since the test clock may stop right after it.
  always_ff @(posedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      drive <= 1'b0;
      prog_t <= 1'b0;
    end else begin
      if (state == jbsp_pkg::JBSP_RESET) begin
        drive <= 1'b0;
      end else if (state == jbsp_pkg::JBSP_UPD_IR) begin
        drive <= P_HAS_BSR && ir_sh == `JBSP_OP_EXTEST;
      end
      if (state == jbsp_pkg::JBSP_UPD_IR && ir_sh == `JBSP_OP_PROG_ENTER) begin
        prog_t <= 1'b1;
      end else if (state == jbsp_pkg::JBSP_UPD_IR && ir_sh == `JBSP_OP_PROG_EXIT) begin
        prog_t <= 1'b0;
      end
    end
  end

  // Serial output bit of the selected data register.
  always_comb begin
    case (sel)
      jbsp_pkg::JBSP_DR_ID: dr_out = id_sh[0];
      jbsp_pkg::JBSP_DR_BSR: dr_out = bsr[0];
      jbsp_pkg::JBSP_DR_ADDR: dr_out = addr_sh[0];
      jbsp_pkg::JBSP_DR_DATA: dr_out = data_sh[0];
      default: dr_out = bypass;
    endcase
  end

  // Serial output changes on the falling edge, giving the receiver half a period of setup.
  always_ff @(negedge i_tck or negedge trst_n) begin
    if (!trst_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      o_tdo <= (state == jbsp_pkg::JBSP_SH_IR) ? ir_sh[0] : dr_out;
      o_tdo_oe <= en_t2 && (state == jbsp_pkg::JBSP_SH_IR || state == jbsp_pkg::JBSP_SH_DR);
    end
  end

  // Link-domain words reach the system domain by toggle handshakes; the words stay still meanwhile.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      upd_s <= 3'h0;
      wr_s <= 3'h0;
      drv_s1 <= 1'b0;
      drv_s2 <= 1'b0;
      prog_s1 <= 1'b0;
      prog_s2 <= 1'b0;
      upd_c <= '0;
      uin_s1 <= 3'h0;
      uin_s2 <= 3'h0;
    end else begin
      upd_s <= {upd_s[1:0], upd_tog};
      wr_s <= {wr_s[1:0], wr_tog};
      drv_s1 <= drive;
      drv_s2 <= drv_s1;
      prog_s1 <= prog_t;
      prog_s2 <= prog_s1;
      // The test latch is copied only on a seen toggle, when it has stood still for two cycles.
      if (upd_s[2] ^ upd_s[1]) begin
        upd_c <= upd;
      end
      uin_s1 <= {i_tck, i_tms, i_tdi};
      uin_s2 <= uin_s1;
    end
  end

  // Pin drivers: core values in normal and sample modes, the test latch under extest.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
    end else begin
      o_pin_out <= drv_s2 ? upd_c : i_core_out;
      o_pin_oe <= drv_s2 ? {`JBSP_BSR_W{1'b1}} : i_core_oe;
    end
  end

  // Programming outputs; the write pulse lasts one system cycle per data update made in programming mode.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_mode <= 1'b0;
      o_prog_wr <= 1'b0;
      o_prog_addr <= '0;
      o_prog_data <= '0;
    end else begin
      o_prog_mode <= prog_s2;
      o_prog_wr <= wr_s[2] ^ wr_s[1];
      if (wr_s[2] ^ wr_s[1]) begin
        o_prog_addr <= addr_hold;
        o_prog_data <= data_hold;
      end
    end
  end

  // With the port disabled, its pins serve the user logic.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_user_in <= 3'h0;
      o_user_out <= 1'b0;
      o_user_oe <= 1'b0;
    end else begin
      o_user_in <= en_clk ? 3'h0 : uin_s2;
      o_user_out <= i_user_tdo;
      o_user_oe <= !en_clk && en_done && i_user_tdo_oe;
    end
  end

  // Captured instruction pattern ends in binary 01.
  ir_capture_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_CAP_IR |=> ir_sh == `JBSP_IR_CAPTURE)
    else $error("instruction capture pattern wrong");
  ir_shift_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_SH_IR |=> ir_sh == {$past(i_tdi), $past(ir_sh[9:1])})
    else $error("instruction register did not shift");
  bypass_delay_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_SH_DR && sel == jbsp_pkg::JBSP_DR_BYPASS |=> bypass == $past(i_tdi))
    else $error("bypass stage lost data");
  id_capture_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_CAP_DR |=> id_sh[0] && id_sh[31:1] == P_IDCODE[31:1])
    else $error("identification capture wrong");
  reset_selects_id_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_RESET |=> ir == `JBSP_OP_IDCODE)
    else $error("reset did not select identification");
  sample_quiet_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    $past(ir) == `JBSP_OP_SAMPLE && ir == `JBSP_OP_SAMPLE |-> !drive)
    else $error("sample disturbed the pins");
  extest_update_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_UPD_DR && sel == jbsp_pkg::JBSP_DR_BSR |=> upd == $past(bsr))
    else $error("test pattern not latched");
  small_bypass_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    !P_HAS_BSR && ir == `JBSP_OP_EXTEST |-> sel == jbsp_pkg::JBSP_DR_BYPASS)
    else $error("extest without cells did not pick bypass");
  prog_enter_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    state == jbsp_pkg::JBSP_UPD_IR && ir_sh == `JBSP_OP_PROG_ENTER |=> prog_t)
    else $error("programming mode not entered");
  tdo_enable_a: assert property (@(posedge i_tck) disable iff (!trst_n)
    o_tdo_oe |-> en_t2 && (state == jbsp_pkg::JBSP_SH_IR || state == jbsp_pkg::JBSP_SH_DR))
    else $error("serial output driven outside shift");
endmodule : jbsp_top

// >>> tb/jbsp_ctl_model.sv
// Behavioural external test controller that steps the test port of the device.
`timescale 1ns/1ps
module jbsp_ctl_model (
  // Test port pins driven toward the device.
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  // Serial data returned by the device.
  input wire logic i_tdo
);
  // The test clock stands still low between frames.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One test clock of 12 ns; the serial output is taken at the rising edge, half a period after it changed.
  task automatic step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #6;
    q = i_tdo;
    o_tck = 1'b1;
    #3;
    o_tdi = ~d; // After the hold time the data line must not keep showing the last value.
    #3;
    o_tck = 1'b0;
  endtask : step
  // Walks idle, select, capture and shift, then exits through update back to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
  // Drives the port pins as plain levels while they serve as user pins.
  task automatic pins(input logic [2:0] v);
    {o_tck, o_tms, o_tdi} = v;
  endtask : pins
endmodule : jbsp_ctl_model

// >>> tb/jtag_boundary_scan_port_test.sv
// Self-checking bench of the boundary-scan test port against the controller model.
`timescale 1ns/1ps
`include "jbsp_regs.svh"
module jtag_boundary_scan_port_test;
  localparam logic [31:0] ID = 32'h5A5A_C3A6; // Arbitrary identification value, bit 0 left low on purpose.
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_port_en = 1'b1, i_user_tdo = 1'b0, i_user_tdo_oe = 1'b0, sel2 = 1'b0;
  logic [7:0] i_pin_in = 8'h00, i_core_out = 8'h00, i_core_oe = 8'h00;
  wire tck, tms, tdi, tdo, tdo_oe, tdo2, prog_mode, prog_wr, user_out, user_oe;
  wire [2:0] user_in;
  wire [7:0] pin_out, pin_oe;
  wire [15:0] prog_addr, prog_data;
  int errors = 0, n_checks = 0, cycles = 0, w;
  logic [31:0] q, pat, lat;
  logic [15:0] a, d;
  // System clock of 50 MHz.
  always #10 i_clk = ~i_clk;
  // The controller listens to whichever device the scenario selects.
  jbsp_ctl_model i_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(sel2 ? tdo2 : tdo));
  jbsp_top #(.P_HAS_BSR(1'b1), .P_IDCODE(ID)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_port_en(i_port_en), .i_user_tdo(i_user_tdo),
    .i_user_tdo_oe(i_user_tdo_oe), .o_user_in(user_in), .o_user_out(user_out), .o_user_oe(user_oe),
    .i_pin_in(i_pin_in), .i_core_out(i_core_out), .i_core_oe(i_core_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_prog_mode(prog_mode), .o_prog_wr(prog_wr), .o_prog_addr(prog_addr), .o_prog_data(prog_data));
  // A small variant without scan cells shares the same controller.
  jbsp_top #(.P_HAS_BSR(1'b0), .P_IDCODE(ID)) i_dut_small (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo2), .o_tdo_oe(), .i_port_en(i_port_en), .i_user_tdo(i_user_tdo),
    .i_user_tdo_oe(i_user_tdo_oe), .o_user_in(), .o_user_out(), .o_user_oe(), .i_pin_in(i_pin_in),
    .i_core_out(i_core_out), .i_core_oe(i_core_oe), .o_pin_out(), .o_pin_oe(), .o_prog_mode(), .o_prog_wr(),
    .o_prog_addr(), .o_prog_data());
  // Compares a seen value with the expected one.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // A one-stage path returns a zero first, then the input one clock late.
  function automatic logic [31:0] byp(input logic [31:0] din, input int n);
    return (din << 1) & ((32'h1 << n) - 1);
  endfunction : byp
  task automatic clks(input int n);
    repeat (n) @(negedge i_clk);
  endtask : clks
  // New random pin and core levels, applied at the falling edge.
  task automatic rnd_pins();
    @(negedge i_clk);
    pat = $urandom;
    i_pin_in = pat[7:0];
    i_core_out = pat[15:8];
    i_core_oe = pat[23:16];
    i_user_tdo = pat[24];
    i_user_tdo_oe = pat[25];
  endtask : rnd_pins
  // Loads an instruction; the capture value comes back while it shifts in.
  task automatic op(input logic [9:0] o);
    i_ctl.scan(1'b1, `JBSP_IR_W, {22'h0, o}, q);
    check("ir capture", q, 32'(`JBSP_IR_CAPTURE));
  endtask : op
  // Counts write pulses over a window longer than the write latency.
  task automatic count_wr();
    w = 0;
    repeat (20) begin
      @(negedge i_clk);
      if (prog_wr === 1'b1) w++;
    end
  endtask : count_wr
  // A hang is cut short well beyond the expected run length.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // Main sequence.
  initial begin
    pat = $urandom(87);
    fork
      repeat (3) i_ctl.step(1'b1, 1'b0, q[0]);
      repeat (2) @(posedge i_clk);
    join
    @(negedge i_clk) i_rst_n = 1'b1;
    clks(4);
    repeat (5) i_ctl.step(1'b1, 1'b0, q[0]);
    i_ctl.scan(1'b0, `JBSP_ID_W, $urandom, q);
    check("idcode", q, ID | 32'h1);
    check("tdo enable idle", 32'(tdo_oe), 32'h0);
    check("user in", 32'(user_in), 32'h0);
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 16'(`JBSP_OP_BYPASS) : 16'h0100 | 16'($urandom_range(2, 80) << 1);
      op(a[9:0]);
      lat = $urandom;
      i_ctl.scan(1'b0, 8, lat, q);
      check("bypass", q, byp(lat, 8));
    end
    rnd_pins();
    op(`JBSP_OP_SAMPLE);
    sel2 = 1'b1;
    i_ctl.scan(1'b0, 8, pat, q);
    check("small sample", q, byp(pat, 8));
    sel2 = 1'b0;
    lat = $urandom;
    i_ctl.scan(1'b0, `JBSP_BSR_W, lat, q);
    check("sample capture", q, 32'(i_pin_in));
    clks(8);
    check("sample pins", 32'({pin_out, pin_oe}), 32'({i_core_out, i_core_oe}));
    op(`JBSP_OP_EXTEST);
    clks(8);
    check("extest preload", 32'({pin_out, pin_oe}), {16'h0, lat[7:0], 8'hFF});
    rnd_pins();
    sel2 = 1'b1;
    i_ctl.scan(1'b0, 8, pat, q);
    check("small extest", q, byp(pat, 8));
    sel2 = 1'b0;
    lat = $urandom;
    i_ctl.scan(1'b0, `JBSP_BSR_W, lat, q);
    check("extest capture", q, 32'(i_pin_in));
    clks(8);
    check("extest drive", 32'(pin_out), 32'(lat[7:0]));
    op(`JBSP_OP_PROG_DATA);
    i_ctl.scan(1'b0, `JBSP_PROG_W, $urandom, q);
    count_wr();
    check("write outside mode", w, 32'h0);
    op(`JBSP_OP_PROG_ENTER);
    clks(6);
    check("prog mode on", 32'(prog_mode), 32'h1);
    a = 16'($urandom);
    d = 16'($urandom);
    op(`JBSP_OP_PROG_ADDR);
    i_ctl.scan(1'b0, `JBSP_PROG_W, 32'(a), q);
    op(`JBSP_OP_PROG_DATA);
    i_ctl.scan(1'b0, `JBSP_PROG_W, 32'(d), q);
    count_wr();
    check("write pulses", w, 32'h1);
    check("prog word", {prog_addr, prog_data}, {a, d});
    op(`JBSP_OP_PROG_EXIT);
    clks(6);
    check("prog mode off", 32'(prog_mode), 32'h0);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    i_port_en = 1'b0;
    clks(2);
    i_rst_n = 1'b1;
    clks(4);
    for (int k = 0; k < 6; k++) begin
      rnd_pins();
      i_ctl.pins(pat[30:28]);
      clks(5);
      check("user pins in", 32'(user_in), 32'(pat[30:28]));
      check("user pin out", 32'({user_out, user_oe, tdo_oe}), 32'({pat[24], pat[25], 1'b0}));
    end
    stop_test();
  end
endmodule : jtag_boundary_scan_port_test
